/* apcsp_core.sv */
`timescale 1ns/1ps
`default_nettype none

module apcsp_core #(
	parameter logic [23:0] TEST_PATTERN = apcsp_pkg::TEST_WORD
) (
	// clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	// static configuration pins
	input  wire logic [1:0]                      mode_sel,
	input  wire logic                            clock_divide_select,
	input  wire logic [2:0]                      format_sel,
	input  wire logic [1:0]                      test_sel,
	// channel control pins
	input  wire logic [apcsp_pkg::CH_COUNT-1:0]  channel_sleep_n,
	input  wire logic                            sync_n,
	// results from the filters and modulators
	input  wire logic [apcsp_pkg::FRAME_BITS-1:0] sample_data,
	input  wire logic [apcsp_pkg::CH_COUNT-1:0]  modulator_bits,
	// serial clock pin
	input  wire logic                            sclk_in,
	output logic                                 sclk_out,
	output logic                                 sclk_oe_n,
	// ready / frame pin
	input  wire logic                            ready_or_frame_pin_in,
	output logic                                 conversion_ready_n,
	output logic                                 ready_or_frame_pin_oe_n,
	// serial data
	input  wire logic                            daisy_in,
	output logic [apcsp_pkg::CH_COUNT-1:0]       data_out,
	// state seen by the analog side
	output logic [1:0]                           active_mode,
	output logic [apcsp_pkg::CH_COUNT-1:0]       channel_powered,
	output logic                                 test_active
);

	localparam int FB = apcsp_pkg::FRAME_BITS;
	localparam int WB = apcsp_pkg::WORD_BITS;
	localparam int CN = apcsp_pkg::CH_COUNT;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------

	// conversion period from mode and divide select
	function automatic logic [11:0] conv_period(input logic [1:0] m, input logic full);
		logic [11:0] p;
		p = apcsp_pkg::PERIOD_HS;
		case (apcsp_pkg::apcsp_mode_t'(m))
			apcsp_pkg::APCSP_HIGH_SPEED: p = apcsp_pkg::PERIOD_HS;
			apcsp_pkg::APCSP_HIGH_RES:   p = apcsp_pkg::PERIOD_HR;
			apcsp_pkg::APCSP_LOW_POWER:  p = full ? apcsp_pkg::PERIOD_LP_FULL : apcsp_pkg::PERIOD_LP_DIV;
			apcsp_pkg::APCSP_LOW_SPEED:  p = full ? apcsp_pkg::PERIOD_LS_FULL : apcsp_pkg::PERIOD_LS_DIV;
			default:                     p = apcsp_pkg::PERIOD_HS;
		endcase
		return p;
	endfunction

	// slot layout: channel one first; sleeping slots are zero or squeezed out
	function automatic logic [FB-1:0] build_frame(input logic [FB-1:0] d, input logic [CN-1:0] act,
	                                              input logic pack);
		logic [FB-1:0] f;
		int            k;
		f = '0;
		k = 0;
		for (int c = 0; c < CN; c++) begin
			if (act[c]) begin
				f[FB-1-WB*k -: WB] = d[WB*c +: WB];
				k++;
			end else if (!pack) begin
				k++;
			end
		end
		return f;
	endfunction

	// line picks: TDM takes the top bit on line one, discrete one slot a line
	function automatic logic [CN-1:0] out_lines(input logic [FB-1:0] s, input logic tdm);
		logic [CN-1:0] l;
		l = '0;
		for (int c = 0; c < CN; c++) begin
			l[c] = tdm ? ((c == 0) ? s[FB-1] : 1'b0) : s[FB-1-WB*c];
		end
		return l;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [apcsp_pkg::SYNC_BITS-1:0] pin_meta;
	logic [apcsp_pkg::SYNC_BITS-1:0] pin_sync;
	logic                            sclk_prev;
	logic                            frame_prev;

	// every pin crosses two flops; static pins too, they may move at any time
	always_ff @(posedge clk) begin
		pin_meta <= {mode_sel, clock_divide_select, format_sel, test_sel, channel_sleep_n,
		             sync_n, daisy_in, sclk_in, ready_or_frame_pin_in};
		pin_sync <= pin_meta;
	end

	wire logic [1:0]    s_mode   = pin_sync[19:18];
	wire logic          s_div    = pin_sync[17];
	wire logic [2:0]    s_fmt    = pin_sync[16:14];
	wire logic [1:0]    s_test   = pin_sync[13:12];
	wire logic [CN-1:0] s_sleep  = pin_sync[11:4];
	wire logic          s_sync_n = pin_sync[3];
	wire logic          s_daisy  = pin_sync[2];
	wire logic          s_sclk   = pin_sync[1];
	wire logic          s_frame  = pin_sync[0];

	// edge history taken from the second flop only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_prev  <= 1'b0;
			frame_prev <= 1'b0;
		end else begin
			sclk_prev  <= s_sclk;
			frame_prev <= s_frame;
		end
	end

	// ------------------------------------------------------------
	// format and mode decode
	// ------------------------------------------------------------
	wire logic fmt_mod   = (s_fmt == apcsp_pkg::FMT_MODULATOR) || (s_fmt == 3'h7);
	wire logic fmt_spi   = !fmt_mod && (s_fmt >= apcsp_pkg::FMT_SPI_TDM_DYN);
	wire logic fmt_fs    = !fmt_mod && !fmt_spi;
	wire logic fmt_tdm   = (s_fmt != apcsp_pkg::FMT_FS_DISCRETE) && (s_fmt != apcsp_pkg::FMT_SPI_DISCRETE);
	wire logic fmt_pack  = (s_fmt == apcsp_pkg::FMT_FS_TDM_DYN) || (s_fmt == apcsp_pkg::FMT_SPI_TDM_DYN);
	wire logic test_on   = (s_test == apcsp_pkg::TEST_ACTIVE);
	wire logic sclk_fall = sclk_prev && !s_sclk;
	wire logic frame_rise = s_frame && !frame_prev;

	// ------------------------------------------------------------
	// channel power filter
	// ------------------------------------------------------------
	logic [1:0] sleep_cnt [CN];
	logic [CN-1:0] powered;

	// a channel drops only after its sleep input stays low for two clocks
	always_ff @(posedge clk) begin
		for (int c = 0; c < CN; c++) begin
			if (!rst_n || s_sleep[c]) begin
				sleep_cnt[c] <= 2'h0;
			end else if (sleep_cnt[c] != apcsp_pkg::SLEEP_HOLD_CLKS) begin
				sleep_cnt[c] <= sleep_cnt[c] + 2'h1;
			end
		end
	end

	always_comb begin
		for (int c = 0; c < CN; c++) begin
			powered[c] = (sleep_cnt[c] != apcsp_pkg::SLEEP_HOLD_CLKS);
		end
	end

	wire logic none_powered = ~|powered;

	// ------------------------------------------------------------
	// conversion timing
	// ------------------------------------------------------------
	logic [11:0] conv_cnt;
	wire  logic [11:0] period   = conv_period(s_mode, s_div);
	wire  logic        conv_tick = (conv_cnt >= period - 12'h001);

	// sync low holds every channel at the start of a conversion together
	always_ff @(posedge clk) begin
		if (!rst_n || !s_sync_n || conv_tick) begin
			conv_cnt <= 12'h000;
		end else begin
			conv_cnt <= conv_cnt + 12'h001;
		end
	end

	// ------------------------------------------------------------
	// mode change settling
	// ------------------------------------------------------------
	logic [1:0] mode_prev;
	logic [7:0] settle_cnt;
	wire  logic mode_changed = (s_mode != mode_prev);
	wire  logic settling     = (settle_cnt != 8'h00);

	// mode pins are live; a change restarts the settle count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_prev  <= 2'h0;
			settle_cnt <= 8'h00;
		end else begin
			mode_prev <= s_mode;
			if (mode_changed) begin
				settle_cnt <= fmt_spi ? apcsp_pkg::SETTLE_SPI : apcsp_pkg::SETTLE_FS;
			end else if (conv_tick && settling) begin
				settle_cnt <= settle_cnt - 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// result capture and shifting
	// ------------------------------------------------------------
	logic [FB-1:0] result_hold;
	logic [FB-1:0] shift_reg;

	// test mode replaces every channel word with a fixed pattern
	wire logic [FB-1:0] raw_words   = test_on ? {CN{TEST_PATTERN}} : sample_data;
	wire logic [FB-1:0] fresh_frame = build_frame(raw_words, powered, fmt_pack);
	wire logic spi_load = fmt_spi && conv_tick;
	wire logic fs_load  = fmt_fs && frame_rise;

	// load wins over shift; the daisy bit enters at the tail
	wire logic [FB-1:0] next_shift =
		spi_load  ? fresh_frame :
		fs_load   ? result_hold :
		sclk_fall ? {shift_reg[FB-2:0], s_daisy} :
		shift_reg;

	wire logic [CN-1:0] next_lines =
		fmt_mod                ? modulator_bits :
		(fmt_fs && settling)   ? {CN{1'b0}} :
		out_lines(next_shift, fmt_tdm);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			result_hold <= '0;
			shift_reg   <= '0;
			data_out    <= '0;
		end else begin
			if (conv_tick) begin
				result_hold <= fresh_frame;
			end
			shift_reg <= next_shift;
			data_out  <= next_lines;
		end
	end

	// ------------------------------------------------------------
	// data ready and pin directions
	// ------------------------------------------------------------

	// ready stays high while settling or with every channel asleep
	always_ff @(posedge clk) begin
		if (!rst_n || !fmt_spi) begin
			conversion_ready_n <= 1'b1;
		end else if (spi_load) begin
			conversion_ready_n <= settling || none_powered;
		end else if (sclk_fall) begin
			conversion_ready_n <= 1'b1;
		end
	end

	// modulator clock is half the master clock, a simple toggle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_out                <= 1'b0;
			sclk_oe_n               <= 1'b1;
			ready_or_frame_pin_oe_n <= 1'b1;
			active_mode             <= 2'h0;
			channel_powered         <= '0;
			test_active             <= 1'b0;
		end else begin
			sclk_out                <= fmt_mod ? !sclk_out : 1'b0;
			sclk_oe_n               <= !fmt_mod;
			ready_or_frame_pin_oe_n <= !fmt_spi;
			active_mode             <= s_mode;
			channel_powered         <= powered;
			test_active             <= test_on;
		end
	end

endmodule
`default_nettype wire

/* apcsp_pkg.sv */
package apcsp_pkg;

	// ------------------------------------------------------------
	// channel and word layout
	// ------------------------------------------------------------
	localparam int CH_COUNT   = 8;
	localparam int WORD_BITS  = 24;
	localparam int FRAME_BITS = CH_COUNT * WORD_BITS;

	// ------------------------------------------------------------
	// operating modes, in pin code order 00..11
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		APCSP_HIGH_SPEED,
		APCSP_HIGH_RES,
		APCSP_LOW_POWER,
		APCSP_LOW_SPEED
	} apcsp_mode_t;

	// ------------------------------------------------------------
	// interface format codes
	// ------------------------------------------------------------
	localparam logic [2:0] FMT_FS_TDM_DYN   = 3'h0;
	localparam logic [2:0] FMT_FS_TDM_FIX   = 3'h1;
	localparam logic [2:0] FMT_FS_DISCRETE  = 3'h2;
	localparam logic [2:0] FMT_SPI_TDM_DYN  = 3'h3;
	localparam logic [2:0] FMT_SPI_TDM_FIX  = 3'h4;
	localparam logic [2:0] FMT_SPI_DISCRETE = 3'h5;
	localparam logic [2:0] FMT_MODULATOR    = 3'h6;

	// ------------------------------------------------------------
	// test select codes
	// ------------------------------------------------------------
	localparam logic [1:0] TEST_NORMAL = 2'h0;
	localparam logic [1:0] TEST_ACTIVE = 2'h3;

	// ------------------------------------------------------------
	// conversion periods in master clock periods
	// ------------------------------------------------------------
	localparam logic [11:0] PERIOD_HS       = 12'h100; // 256
	localparam logic [11:0] PERIOD_HR       = 12'h200; // 512
	localparam logic [11:0] PERIOD_LP_FULL  = 12'h200; // 512
	localparam logic [11:0] PERIOD_LP_DIV   = 12'h100; // 256
	localparam logic [11:0] PERIOD_LS_FULL  = 12'ha00; // 2560
	localparam logic [11:0] PERIOD_LS_DIV   = 12'h200; // 512

	// ------------------------------------------------------------
	// settling after a mode change, in conversions
	// ------------------------------------------------------------
	localparam logic [7:0] SETTLE_SPI = 8'h81; // 129
	localparam logic [7:0] SETTLE_FS  = 8'h80; // 128

	// ------------------------------------------------------------
	// power-down filter and test word
	// ------------------------------------------------------------
	localparam logic [1:0]  SLEEP_HOLD_CLKS = 2'h2;
	localparam logic [23:0] TEST_WORD       = 24'h5a_a5_5a;

	// synchroniser vector width
	localparam int SYNC_BITS = 20;

endpackage

/* apcsp_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// port checker for apcsp_core
// --------------------------------
module apcsp_checker (
	// clock and reset
	input wire logic                           clk,
	input wire logic                           rst_n,
	// pins in
	input wire logic [1:0]                     mode_sel,
	input wire logic [2:0]                     format_sel,
	input wire logic [1:0]                     test_sel,
	input wire logic [apcsp_pkg::CH_COUNT-1:0] channel_sleep_n,
	input wire logic                           sclk_in,
	// pins out
	input wire logic                           sclk_out,
	input wire logic                           sclk_oe_n,
	input wire logic                           conversion_ready_n,
	input wire logic                           ready_or_frame_pin_oe_n,
	input wire logic [apcsp_pkg::CH_COUNT-1:0] data_out,
	input wire logic [1:0]                     active_mode,
	input wire logic [apcsp_pkg::CH_COUNT-1:0] channel_powered,
	input wire logic                           test_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// cycles since ready fell; saturates so long idle spans cannot wrap
	logic [11:0] gap;
	always_ff @(posedge clk) begin
		if (!rst_n)
			gap <= 12'hfff;
		else
			gap <= $fell(conversion_ready_n) ? 12'h000 : (gap == 12'hfff ? gap : gap + 12'h001);
	end

	// formats held long enough to pass the pin synchronisers
	sequence spi_held;
		(format_sel inside {3'h3, 3'h4, 3'h5}) [*5];
	endsequence
	sequence mod_held;
		(format_sel[2:1] == 2'b11) [*5];
	endsequence

	a_idle_after_reset: assert property (
		$rose(rst_n) |-> conversion_ready_n && sclk_oe_n && ready_or_frame_pin_oe_n && data_out == '0)
		else $error("outputs not idle after reset");
	a_ready_pin_out: assert property (
		spi_held |-> !ready_or_frame_pin_oe_n)
		else $error("ready pin not driven in spi");
	a_frame_pin_in: assert property (
		(format_sel <= 3'h2) [*5] |-> ready_or_frame_pin_oe_n && conversion_ready_n)
		else $error("frame pin driven in frame-sync");
	a_mod_clock_out: assert property (
		mod_held |-> !sclk_oe_n && sclk_out != $past(sclk_out))
		else $error("modulator clock missing");
	a_sclk_pin_in: assert property (
		(format_sel[2:1] != 2'b11) [*5] |-> sclk_oe_n && !sclk_out)
		else $error("serial clock pin driven");
	a_conv_gap_min: assert property (
		$fell(conversion_ready_n) && gap != 12'hfff |-> gap >= 12'h0ff)
		else $error("conversions closer than 256 clocks");
	a_ready_release: assert property (
		$fell(sclk_in) && !conversion_ready_n && !ready_or_frame_pin_oe_n |-> ##[2:6] conversion_ready_n)
		else $error("ready not released after serial clock fall");
	a_test_flag_seen: assert property (
		$stable(test_sel) [*5] |-> test_active == (test_sel == apcsp_pkg::TEST_ACTIVE))
		else $error("test flag wrong");
	a_mode_tracked: assert property (
		$stable(mode_sel) [*5] |-> active_mode == mode_sel)
		else $error("mode not applied");
	a_sleep_tracked: assert property (
		$stable(channel_sleep_n) [*6] |-> channel_powered == channel_sleep_n)
		else $error("channel power state wrong");
endmodule

bind apcsp_core apcsp_checker apcsp_checker_i (.clk, .rst_n, .mode_sel, .format_sel, .test_sel, .channel_sleep_n,
	.sclk_in, .sclk_out, .sclk_oe_n, .conversion_ready_n, .ready_or_frame_pin_oe_n, .data_out, .active_mode,
	.channel_powered, .test_active);
`default_nettype wire

/* apcsp_host.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// host reading the serial port
// --------------------------------
module apcsp_host (
	// clock
	input wire logic       clk,
	// device pins
	input wire logic       ready_pin,
	input wire logic [7:0] data_out,
	// host pins
	output logic           sclk,
	output logic           frame
);
	logic       spi_clk = 1'b0;
	logic       fs_clk  = 1'b0;
	logic       fs_run  = 1'b0;
	logic [1:0] div     = 2'h0;
	int         timeouts = 0;
	assign sclk = fs_run ? fs_clk : spi_clk;
	initial frame = 1'b0;

	// free clk/8 clock; moves on clk falls so skew to clk stays nil
	always @(negedge clk) begin
		if (fs_run) begin
			div <= div + 2'h1;
			fs_clk <= (div == 2'h3) ? ~fs_clk : fs_clk;
		end
	end

	task automatic fs_mode(input logic on);
		fs_run <= on;
	endtask

	// bounded so a dead ready line cannot hang the run
	task automatic wait_ready(input logic v);
		int n;
		n = 0;
		while (ready_pin !== v && n < 700) begin
			@(negedge clk);
			n++;
		end
		if (n >= 700) timeouts++;
	endtask

	// flush a stale word first, then read a fresh one at clk/8
	task automatic spi_read(output logic [23:0] l0, output logic [23:0] l1);
		wait_ready(1'b0);
		spi_clk <= 1'b1;
		repeat (4) @(negedge clk);
		spi_clk <= 1'b0;
		wait_ready(1'b1);
		wait_ready(1'b0);
		repeat (2) @(negedge clk);
		for (int i = 0; i < 24; i++) begin
			spi_clk <= 1'b1;
			repeat (4) @(negedge clk);
			l0 = {l0[22:0], data_out[0]};
			l1 = {l1[22:0], data_out[1]};
			spi_clk <= 1'b0;
			repeat (4) @(negedge clk);
		end
	endtask

	// frame rises mid low half, bits taken just before each fall
	task automatic fs_read(output logic [23:0] l0);
		@(negedge fs_clk);
		repeat (2) @(negedge clk);
		frame <= 1'b1;
		for (int i = 0; i < 24; i++) begin
			@(negedge fs_clk);
			l0 = {l0[22:0], data_out[0]};
			frame <= (i == 0);
		end
	endtask
endmodule
`default_nettype wire

/* apcsp_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	// --------------------------------
	// pins and wiring
	// --------------------------------
	logic         clk        = 1'b0;
	logic         rst_n      = 1'b0;
	logic [1:0]   mode_sel   = 2'h0;
	logic [2:0]   format_sel = 3'h4;
	logic [1:0]   test_sel   = 2'h0;
	logic [7:0]   sleep_n    = 8'hff;
	logic         sync_n     = 1'b1;
	logic         daisy      = 1'b1;
	logic [7:0]   mod_bits   = 8'h00;
	logic [191:0] sample_data;
	logic         sclk_out;
	logic         sclk_oe_n;
	logic         ready_n;
	logic         ready_oe_n;
	logic         test_active;
	logic [7:0]   data_out;
	logic [7:0]   powered;
	logic [1:0]   active_mode;
	logic [23:0]  l0;
	logic [23:0]  l1;
	wire          host_sclk;
	wire          host_frame;
	int           bad_count = 0;
	int           compares  = 0;
	int           n;
	// whoever enables its driver owns the shared pin
	wire sclk_pin  = sclk_oe_n ? host_sclk : sclk_out;
	wire frame_pin = ready_oe_n ? host_frame : ready_n;
	always #5 clk = ~clk;

	apcsp_core apcsp_core_i (.clk(clk), .rst_n(rst_n), .mode_sel(mode_sel), .clock_divide_select(1'b1),
		.format_sel(format_sel), .test_sel(test_sel), .channel_sleep_n(sleep_n), .sync_n(sync_n),
		.sample_data(sample_data), .modulator_bits(mod_bits), .sclk_in(sclk_pin), .sclk_out(sclk_out),
		.sclk_oe_n(sclk_oe_n), .ready_or_frame_pin_in(frame_pin), .conversion_ready_n(ready_n),
		.ready_or_frame_pin_oe_n(ready_oe_n), .daisy_in(daisy), .data_out(data_out), .active_mode(active_mode),
		.channel_powered(powered), .test_active(test_active));
	apcsp_host apcsp_host_i (.clk(clk), .ready_pin(frame_pin), .data_out(data_out), .sclk(host_sclk),
		.frame(host_frame));

	function automatic logic [23:0] word(input int c);
		return 24'h81_4c_2e + 24'(c) * 24'h01_0203;
	endfunction

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic count_falls(input int cycles, output int k);
		logic prev;
		k = 0;
		prev = ready_n;
		repeat (cycles) begin
			@(negedge clk);
			if (prev && !ready_n) k++;
			prev = ready_n;
		end
	endtask

	task automatic wrap_up;
		bad_count += apcsp_host_i.timeouts;
		if (bad_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic s_spi_words;
		apcsp_host_i.spi_read(l0, l1);
		chk("tdm word", word(0), l0);
		chk("ready pin dir", 24'h0, ready_oe_n);
		format_sel = 3'h5;
		apcsp_host_i.spi_read(l0, l1);
		chk("line0 word", word(0), l0);
		chk("line1 word", word(1), l1);
		format_sel = 3'h4;
		test_sel = 2'h3;
		apcsp_host_i.spi_read(l0, l1);
		chk("test word", apcsp_pkg::TEST_WORD, l0);
		chk("test flag", 24'h1, test_active);
		test_sel = 2'h0;
	endtask

	task automatic s_frame;
		format_sel = 3'h1;
		apcsp_host_i.fs_mode(1'b1);
		repeat (300) @(negedge clk);
		apcsp_host_i.fs_read(l0);
		chk("frame word", word(0), l0);
		chk("frame pin dir", 24'h1, ready_oe_n);
		// after 192 shifts the upstream bits reach line one
		repeat (169) @(negedge apcsp_host_i.fs_clk);
		chk("daisy bit", 24'h1, 24'(data_out[0]));
		apcsp_host_i.fs_mode(1'b0);
	endtask

	// a held sync stalls conversions; release realigns them
	task automatic s_sync;
		format_sel = 3'h4;
		apcsp_host_i.spi_read(l0, l1);
		sync_n = 1'b0;
		count_falls(700, n);
		chk("falls in sync", 24'h0, 24'(n));
		sync_n = 1'b1;
		apcsp_host_i.wait_ready(1'b0);
		chk("ready after sync", 24'h0, ready_n);
	endtask

	task automatic s_modulator;
		for (int f = 6; f < 8; f++) begin
			format_sel = 3'(f);
			mod_bits = 8'h5c ^ 8'(f);
			repeat (12) @(negedge clk);
			chk("sclk dir", 24'h0, sclk_oe_n);
			chk("raw bits", 24'(mod_bits), 24'(data_out));
		end
	endtask

	task automatic s_sleep;
		sleep_n = 8'hfe;
		repeat (8) @(negedge clk);
		chk("powered", 24'hfe, 24'(powered));
		format_sel = 3'h4;
		apcsp_host_i.spi_read(l0, l1);
		chk("fixed slot", 24'h0, l0);
		format_sel = 3'h3;
		apcsp_host_i.spi_read(l0, l1);
		chk("packed slot", word(1), l0);
		sleep_n = 8'h0f;
		repeat (8) @(negedge clk);
		chk("four channel", 24'h0f, 24'(powered));
	endtask

	// settling after a mode change keeps ready up
	task automatic s_mode_change;
		mode_sel = 2'h1;
		repeat (6) @(negedge clk);
		chk("mode", 24'h1, 24'(active_mode));
		count_falls(1500, n);
		chk("falls settling", 24'h0, 24'(n));
		format_sel = 3'h1;
		apcsp_host_i.fs_mode(1'b1);
		apcsp_host_i.fs_read(l0);
		chk("settling frame", 24'h0, l0);
	endtask

	initial begin
		for (int c = 0; c < 8; c++)
			sample_data[24*c+:24] = word(c);
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("ready idle", 24'h1, ready_n);
		s_spi_words();
		s_frame();
		s_sync();
		s_modulator();
		s_sleep();
		s_mode_change();
		wrap_up();
	end

	// whole run needs about eight thousand clocks
	initial begin
		#200_000;
		bad_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
